// file: hw/fpcs_ctrl.sv
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module fpcs_ctrl #(
    parameter logic [21:0] P_UNL1_ADDR = fpcs_pkg::UNL1_ADDR,
    parameter logic [21:0] P_UNL2_ADDR = fpcs_pkg::UNL2_ADDR,
    parameter logic [15:0] P_UNL1_DATA = fpcs_pkg::UNL1_DATA,
    parameter logic [15:0] P_UNL2_DATA = fpcs_pkg::UNL2_DATA,
    parameter logic [15:0] P_CMD_PROG = fpcs_pkg::CMD_PROG,
    parameter logic [15:0] P_CMD_BUF_LOAD = fpcs_pkg::CMD_BUF_LOAD,
    parameter logic [15:0] P_CMD_CONFIRM = fpcs_pkg::CMD_CONFIRM,
    parameter logic [15:0] P_CMD_RESET = fpcs_pkg::CMD_RESET
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // software register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // flash pins
    output logic [21:0] fl_addr_o,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe_o,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_n_o,
    output logic fl_we_n_o,
    output logic fl_oe_n_o,
    output logic fl_reset_n_o
);
    //****************************************************************
    // software registers and acceptance
    //****************************************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETUP = 6'h02,
        ST_PULSE = 6'h04,
        ST_HOLD = 6'h08,
        ST_READ = 6'h10,
        ST_RST = 6'h20
    } fpcs_state_t;

    fpcs_state_t state_r;
    logic [21:0] addr_r;
    logic [15:0] data_r;
    logic [3:0] op_r;
    logic [1:0] idx_r;
    logic [4:0] cnt_r;
    logic prog_busy_r, bypass_r, region_r, buf_r, page_ok_r;
    logic err_r, tout_r, abort_r;
    logic [4:0] remain_r;
    logic [17:0] page_r;
    logic [21:0] last_addr_r;
    logic [15:0] last_data_r;
    logic [15:0] dq_last_r;
    logic go, ok, taken, engine_busy;
    logic [3:0] op_in;
    fpcs_pkg::fpcs_step_t step;

    assign engine_busy = (state_r != ST_IDLE);
    assign go = reg_wr_i && (reg_addr_i == fpcs_pkg::REG_CTRL);
    assign op_in = reg_wdata_i[3:0];
    assign taken = go && ok;

    // hosts must never hand the flash a command it would drop or misread,
    // so every order is screened against the modes we track here
    always_comb begin
        ok = !engine_busy;
        if (prog_busy_r && !(op_in == fpcs_pkg::OP_POLL || op_in == fpcs_pkg::OP_HWRST
                || (op_in == fpcs_pkg::OP_RESET && tout_r) || (op_in == fpcs_pkg::OP_ABORT && abort_r)))
            ok = 1'b0;
        if (bypass_r && !(op_in == fpcs_pkg::OP_BPROG || op_in == fpcs_pkg::OP_BEXIT
                || op_in == fpcs_pkg::OP_POLL || op_in == fpcs_pkg::OP_HWRST))
            ok = 1'b0;
        if ((op_in == fpcs_pkg::OP_BPROG || op_in == fpcs_pkg::OP_BEXIT) && !bypass_r)
            ok = 1'b0;
        if (op_in == fpcs_pkg::OP_BENTER && region_r)
            ok = 1'b0;
        if (op_in == fpcs_pkg::OP_BSTART && (buf_r || data_r[15:4] != 12'h000))
            ok = 1'b0;
        if (op_in == fpcs_pkg::OP_BLOAD && (!buf_r || remain_r == 5'h00
                || (page_ok_r && addr_r[21:4] != page_r)))
            ok = 1'b0;
        if (op_in == fpcs_pkg::OP_BCONF && (!buf_r || remain_r != 5'h00))
            ok = 1'b0;
        if (op_in > fpcs_pkg::OP_HWRST)
            ok = 1'b0;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            addr_r <= 22'h000000;
            data_r <= 16'h0000;
        end else if (reg_wr_i && reg_addr_i == fpcs_pkg::REG_ADDR) begin
            addr_r <= reg_wdata_i[21:0];
        end else if (reg_wr_i && reg_addr_i == fpcs_pkg::REG_DATA) begin
            data_r <= reg_wdata_i[15:0];
        end
    end

    // refused orders latch err; a refusal in the clearing cycle still sets it
    always_ff @(posedge mclk_i) begin
        if (rst_i)
            err_r <= 1'b0;
        else if (go && !ok)
            err_r <= 1'b1;
        else if (reg_wr_i && reg_addr_i == fpcs_pkg::REG_STAT && reg_wdata_i[fpcs_pkg::STAT_ERR_BIT])
            err_r <= 1'b0;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                fpcs_pkg::REG_ADDR: reg_rdata_o <= {10'h000, addr_r};
                fpcs_pkg::REG_DATA: reg_rdata_o <= {16'h0000, data_r};
                fpcs_pkg::REG_STAT: reg_rdata_o <= {dq_last_r, 3'h0, remain_r, abort_r, tout_r, err_r,
                                                    buf_r, region_r, bypass_r, prog_busy_r, engine_busy};
                default: reg_rdata_o <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

    //****************************************************************
    // mode tracking
    //****************************************************************
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bypass_r <= 1'b0;
            region_r <= 1'b0;
            buf_r <= 1'b0;
            page_ok_r <= 1'b0;
            remain_r <= 5'h00;
            page_r <= 18'h00000;
        end else if (state_r == ST_RST && cnt_r == 5'h00) begin
            bypass_r <= 1'b0;
            region_r <= 1'b0;
            buf_r <= 1'b0;
        end else if (taken) begin
            unique case (op_in)
                fpcs_pkg::OP_BENTER: bypass_r <= 1'b1;
                fpcs_pkg::OP_BEXIT: bypass_r <= 1'b0;
                fpcs_pkg::OP_RENTER: region_r <= 1'b1;
                fpcs_pkg::OP_REXIT: region_r <= 1'b0;
                fpcs_pkg::OP_BSTART: begin
                    buf_r <= 1'b1;
                    page_ok_r <= 1'b0;
                    remain_r <= data_r[4:0] + 5'h01;
                end
                fpcs_pkg::OP_BLOAD: begin
                    remain_r <= remain_r - 5'h01;
                    page_ok_r <= 1'b1;
                    page_r <= addr_r[21:4];
                end
                fpcs_pkg::OP_BCONF, fpcs_pkg::OP_ABORT, fpcs_pkg::OP_RESET: buf_r <= 1'b0;
                default: buf_r <= buf_r;
            endcase
        end
    end

    // program tracking and status polling
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prog_busy_r <= 1'b0;
            tout_r <= 1'b0;
            abort_r <= 1'b0;
            last_addr_r <= 22'h000000;
            last_data_r <= 16'h0000;
            dq_last_r <= 16'h0000;
        end else if (state_r == ST_RST && cnt_r == 5'h00) begin
            prog_busy_r <= 1'b0;
            tout_r <= 1'b0;
            abort_r <= 1'b0;
        end else if (taken && (op_in == fpcs_pkg::OP_WORD || op_in == fpcs_pkg::OP_BPROG
                || op_in == fpcs_pkg::OP_BLOAD)) begin
            last_addr_r <= addr_r;
            last_data_r <= data_r;
            prog_busy_r <= (op_in != fpcs_pkg::OP_BLOAD);
        end else if (taken && op_in == fpcs_pkg::OP_BCONF) begin
            prog_busy_r <= 1'b1;
        end else if (taken && (op_in == fpcs_pkg::OP_RESET || op_in == fpcs_pkg::OP_ABORT)) begin
            prog_busy_r <= 1'b0;
            tout_r <= 1'b0;
            abort_r <= 1'b0;
        end else if (state_r == ST_READ && cnt_r == 5'h00) begin
            dq_last_r <= fl_dq_i;
            // once done, dq1 and dq5 are plain array bits, so they count only while dq7 disagrees
            if (prog_busy_r && fl_dq_i[7] == last_data_r[7])
                prog_busy_r <= 1'b0;
            else if (prog_busy_r && fl_dq_i[5])
                tout_r <= 1'b1;
            else if (prog_busy_r && fl_dq_i[1])
                abort_r <= 1'b1;
        end
    end

    //****************************************************************
    // bus cycle engine
    //****************************************************************
    always_comb begin
        step = '{last: 1'b0, addr: P_UNL1_ADDR, data: P_UNL1_DATA};
        if (idx_r == 2'h1)
            step = '{last: 1'b0, addr: P_UNL2_ADDR, data: P_UNL2_DATA};
        unique case (op_r)
            fpcs_pkg::OP_WORD:
                if (idx_r == 2'h2)
                    step = '{last: 1'b0, addr: P_UNL1_ADDR, data: P_CMD_PROG};
                else if (idx_r == 2'h3)
                    step = '{last: 1'b1, addr: addr_r, data: data_r};
            fpcs_pkg::OP_BENTER:
                if (idx_r == 2'h2)
                    step = '{last: 1'b1, addr: P_UNL1_ADDR, data: fpcs_pkg::CMD_BYPASS};
            fpcs_pkg::OP_BPROG:
                if (idx_r == 2'h0)
                    step = '{last: 1'b0, addr: addr_r, data: P_CMD_PROG};
                else
                    step = '{last: 1'b1, addr: addr_r, data: data_r};
            fpcs_pkg::OP_BEXIT, fpcs_pkg::OP_REXIT:
                if (op_r == fpcs_pkg::OP_BEXIT || idx_r[1])
                    step = '{last: idx_r[0], addr: addr_r,
                             data: idx_r[0] ? fpcs_pkg::CMD_EXIT2 : fpcs_pkg::CMD_EXIT1};
            fpcs_pkg::OP_BSTART:
                if (idx_r == 2'h2)
                    step = '{last: 1'b0, addr: addr_r, data: P_CMD_BUF_LOAD};
                else if (idx_r == 2'h3)
                    step = '{last: 1'b1, addr: addr_r, data: data_r};
            fpcs_pkg::OP_BLOAD:
                step = '{last: 1'b1, addr: addr_r, data: data_r};
            fpcs_pkg::OP_BCONF:
                step = '{last: 1'b1, addr: addr_r, data: P_CMD_CONFIRM};
            fpcs_pkg::OP_ABORT:
                if (idx_r == 2'h2)
                    step = '{last: 1'b1, addr: P_UNL1_ADDR, data: P_CMD_RESET};
            fpcs_pkg::OP_RENTER:
                if (idx_r == 2'h2)
                    step = '{last: 1'b1, addr: P_UNL1_ADDR, data: fpcs_pkg::CMD_REGION};
            fpcs_pkg::OP_RESET:
                step = '{last: 1'b1, addr: addr_r, data: P_CMD_RESET};
            default:
                step = '{last: 1'b1, addr: last_addr_r, data: 16'h0000};
        endcase
    end

    // we falls with ce in one cycle and rises a cycle before ce, so the flash latches address
    // on that shared falling edge and data on our rising we
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            op_r <= 4'h0;
            idx_r <= 2'h0;
            cnt_r <= 5'h00;
            fl_addr_o <= 22'h000000;
            fl_dq_o <= 16'h0000;
            fl_dq_oe_o <= 1'b0;
            fl_ce_n_o <= 1'b1;
            fl_we_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            fl_reset_n_o <= 1'b1;
        end else begin
            unique case (state_r)
                ST_IDLE: if (taken) begin
                    op_r <= op_in;
                    idx_r <= 2'h0;
                    if (op_in == fpcs_pkg::OP_HWRST) begin
                        state_r <= ST_RST;
                        fl_reset_n_o <= 1'b0;
                        cnt_r <= 5'(fpcs_pkg::RST_CYC - 1);
                    end else if (op_in == fpcs_pkg::OP_POLL) begin
                        state_r <= ST_READ;
                        // host points addr at the last loaded word to poll; any other word reads back
                        fl_addr_o <= addr_r;
                        fl_ce_n_o <= 1'b0;
                        fl_oe_n_o <= 1'b0;
                        cnt_r <= 5'(fpcs_pkg::ACCESS_CYC - 1);
                    end else begin
                        state_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    fl_addr_o <= step.addr;
                    fl_dq_o <= step.data;
                    fl_dq_oe_o <= 1'b1;
                    fl_ce_n_o <= 1'b0;
                    state_r <= ST_PULSE;
                    fl_we_n_o <= 1'b0;
                    cnt_r <= 5'(fpcs_pkg::WP_CYC - 1);
                end
                ST_PULSE: if (cnt_r == 5'h00) begin
                    fl_we_n_o <= 1'b1;
                    state_r <= ST_HOLD;
                end else begin
                    cnt_r <= cnt_r - 5'h01;
                end
                ST_HOLD: begin
                    fl_ce_n_o <= 1'b1;
                    fl_dq_oe_o <= 1'b0;
                    idx_r <= idx_r + 2'h1;
                    state_r <= step.last ? ST_IDLE : ST_SETUP;
                end
                ST_READ: if (cnt_r == 5'h00) begin
                    fl_ce_n_o <= 1'b1;
                    fl_oe_n_o <= 1'b1;
                    state_r <= ST_IDLE;
                end else begin
                    cnt_r <= cnt_r - 5'h01;
                end
                ST_RST: if (cnt_r == 5'h00) begin
                    fl_reset_n_o <= 1'b1;
                    state_r <= ST_IDLE;
                end else begin
                    cnt_r <= cnt_r - 5'h01;
                end
            endcase
        end
    end

    //****************************************************************
    // checks
    //****************************************************************
    sequence s_unlock;
        ##[1:4] (!fl_we_n_o && fl_dq_o == P_UNL1_DATA) ##[1:8] (!fl_we_n_o && fl_dq_o == P_UNL2_DATA);
    endsequence
    property p_word_seq;
        @(posedge mclk_i) disable iff (rst_i)
        taken && op_in == fpcs_pkg::OP_WORD |-> s_unlock ##[1:8] (!fl_we_n_o && fl_dq_o == P_CMD_PROG);
    endproperty
    a_word_seq: assert property (p_word_seq) else $error("word program order wrong");
    property p_bypass_seq;
        @(posedge mclk_i) disable iff (rst_i)
        taken && op_in == fpcs_pkg::OP_BENTER |-> s_unlock ##[1:8] (!fl_we_n_o && fl_dq_o == fpcs_pkg::CMD_BYPASS);
    endproperty
    a_bypass_seq: assert property (p_bypass_seq) else $error("bypass entry order wrong");
    property p_busy_refuse;
        @(posedge mclk_i) disable iff (rst_i)
        go && prog_busy_r && op_in == fpcs_pkg::OP_WORD |=> err_r && !engine_busy;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("command passed while programming");
    property p_bypass_only;
        @(posedge mclk_i) disable iff (rst_i)
        go && bypass_r && op_in == fpcs_pkg::OP_BSTART |=> err_r && !buf_r;
    endproperty
    a_bypass_only: assert property (p_bypass_only) else $error("non-bypass command in bypass");
    property p_we_in_ce;
        @(posedge mclk_i) disable iff (rst_i)
        !fl_we_n_o |-> !fl_ce_n_o && fl_dq_oe_o && fl_oe_n_o;
    endproperty
    a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside chip select");
    property p_we_width;
        @(posedge mclk_i) disable iff (rst_i)
        $fell(fl_we_n_o) |-> !fl_we_n_o[*2] ##1 fl_we_n_o;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
    property p_hw_reset;
        @(posedge mclk_i) disable iff (rst_i)
        taken && op_in == fpcs_pkg::OP_HWRST |=> !fl_reset_n_o[*8] ##[1:30] (fl_reset_n_o && !prog_busy_r);
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("hardware reset pulse wrong");
    property p_buf_cap;
        @(posedge mclk_i) disable iff (rst_i)
        remain_r <= fpcs_pkg::BUF_WORDS;
    endproperty
    a_buf_cap: assert property (p_buf_cap) else $error("buffer count above capacity");
    property p_load_count;
        @(posedge mclk_i) disable iff (rst_i)
        taken && op_in == fpcs_pkg::OP_BLOAD |=> remain_r == $past(remain_r) - 5'h01;
    endproperty
    a_load_count: assert property (p_load_count) else $error("load count not decremented");
endmodule : fpcs_ctrl
`default_nettype wire

// file: hw/fpcs_pkg.sv
//****************************************************************
// Summary of operation
//****************************************************************
// Summary of operation
// - three-cycle entry sequence puts the flash into its serial-number region.
// - four-cycle exit sequence returns the flash to normal array operation.
// - word program is two unlocks, program set-up, then address with data.
// - hardware reset ends a program at once; host reissues the sequence afterward.
// - bypass entry is two unlocks then command 20h.
// - bypass program is command A0h then address and data, no unlocks.
// - bypass exit writes 90h then 00h, back to read mode.
// - buffer start is two unlocks, load command at sector, then count minus one.
// - first loaded pair picks the page; later pairs stay in it, any order.
// - confirm at sector starts programming; host polls the last loaded address.
// - abort shows abort bit set, inverted polling, toggling, timeout zero; abort reset.
package fpcs_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam int STAT_ERR_BIT = 5;
    // software operation codes
    localparam logic [3:0] OP_WORD = 4'h0;
    localparam logic [3:0] OP_BENTER = 4'h1;
    localparam logic [3:0] OP_BPROG = 4'h2;
    localparam logic [3:0] OP_BEXIT = 4'h3;
    localparam logic [3:0] OP_BSTART = 4'h4;
    localparam logic [3:0] OP_BLOAD = 4'h5;
    localparam logic [3:0] OP_BCONF = 4'h6;
    localparam logic [3:0] OP_ABORT = 4'h7;
    localparam logic [3:0] OP_RENTER = 4'h8;
    localparam logic [3:0] OP_REXIT = 4'h9;
    localparam logic [3:0] OP_RESET = 4'hA;
    localparam logic [3:0] OP_POLL = 4'hB;
    localparam logic [3:0] OP_HWRST = 4'hC;
    // flash command defaults
    localparam logic [21:0] UNL1_ADDR = 22'h000555;
    localparam logic [21:0] UNL2_ADDR = 22'h0002AA;
    localparam logic [15:0] UNL1_DATA = 16'h00AA;
    localparam logic [15:0] UNL2_DATA = 16'h0055;
    localparam logic [15:0] CMD_PROG = 16'h00A0;
    localparam logic [15:0] CMD_BYPASS = 16'h0020;
    localparam logic [15:0] CMD_EXIT1 = 16'h0090;
    localparam logic [15:0] CMD_EXIT2 = 16'h0000;
    localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
    localparam logic [15:0] CMD_CONFIRM = 16'h0029;
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_REGION = 16'h0088;
    localparam logic [4:0] BUF_WORDS = 5'h10;
    // timing
    localparam int CLK_NS = 20;
    localparam int WP_NS = 40;
    localparam int ACCESS_NS = 100;
    localparam int RST_NS = 500;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic last;
        logic [21:0] addr;
        logic [15:0] data;
    } fpcs_step_t;
endpackage : fpcs_pkg

// file: verification/fpcs_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
//****************************************************************
// flash command decoder model
//****************************************************************
module fpcs_flash_model #(
    parameter int SEC_LSB = 15
) (
    // flash pins
    input wire logic [21:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic reset_n_i,
    output logic [15:0] dq_o = 16'hFFFF
);
    logic [15:0] mem [logic [21:0]];
    logic [15:0] bd [logic [21:0]];
    logic [21:0] la, sec;
    logic [15:0] last, ld;
    logic wr_n, byp = 0, abrt = 0, tog = 0;
    int st = 0, busy = 0, cnt = 0;
    assign wr_n = ce_n_i | we_n_i;
    function automatic logic [15:0] rdm(logic [21:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction : rdm
    // cells only go one to zero, status busy for three reads
    task automatic prog(logic [21:0] a, logic [15:0] d);
        mem[a] = rdm(a) & d;
        last = d;
        busy = 3;
    endtask : prog
    always @(negedge wr_n) la = addr_i;
    always @(posedge wr_n) if (reset_n_i && busy == 0) begin
        if (dq_i == fpcs_pkg::CMD_RESET && !byp) begin
            st = 0;
            abrt = 0;
        end else case (st)
            0: if (la == fpcs_pkg::UNL1_ADDR && dq_i == fpcs_pkg::UNL1_DATA) st = 1;
            1: st = (la == fpcs_pkg::UNL2_ADDR && dq_i == fpcs_pkg::UNL2_DATA) ? 2 : 0;
            2: case (dq_i)
                fpcs_pkg::CMD_PROG: st = 3;
                fpcs_pkg::CMD_BYPASS: begin byp = 1; st = 10; end
                fpcs_pkg::CMD_BUF_LOAD: begin sec = la; bd.delete(); st = 20; end
                default: st = 0;
            endcase
            3: begin prog(la, dq_i); st = byp ? 10 : 0; end
            10: st = (dq_i == fpcs_pkg::CMD_PROG) ? 3 : (dq_i == fpcs_pkg::CMD_EXIT1) ? 11 : 10;
            11: begin byp = (dq_i != fpcs_pkg::CMD_EXIT2); st = byp ? 10 : 0; end
            20: begin cnt = dq_i + 1; abrt = dq_i > 15; st = abrt ? 0 : 21; end
            21: if (la[21:SEC_LSB] != sec[21:SEC_LSB] || (bd.size() > 0 && la[21:4] != sec[21:4])) begin
                abrt = 1;
                st = 0;
            end else begin
                bd[la] = dq_i;
                ld = dq_i;
                sec = (bd.size() == 1) ? la : sec;
                cnt--;
                st = (cnt == 0) ? 22 : 21;
            end
            22: begin
                if (dq_i == fpcs_pkg::CMD_CONFIRM) foreach (bd[a]) prog(a, bd[a]);
                else abrt = 1;
                last = ld;
                st = 0;
            end
            default: st = 0;
        endcase
    end
    always @(negedge oe_n_i or negedge ce_n_i) if (!ce_n_i && !oe_n_i) begin
        tog = ~tog;
        if (abrt) dq_o = {8'h00, ~last[7], tog, 6'h02};
        else if (busy > 0) begin dq_o = {8'h00, ~last[7], tog, 6'h00}; busy--; end
        else dq_o = rdm(addr_i);
    end
    // released bus shows the inverse so a stale sample cannot pass
    always @(posedge oe_n_i) dq_o = ~dq_o;
    always @(negedge reset_n_i) begin busy = 0; st = 0; byp = 0; abrt = 0; end
endmodule : fpcs_flash_model
`default_nettype wire

// file: verification/test_flash_program_command_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
//****************************************************************
// bench
//****************************************************************
module test_flash_program_command_sequencer;
    logic mclk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, st;
    logic [21:0] fl_addr_o, a, b;
    logic [15:0] fl_dq_o, fl_dq_i, d;
    logic fl_dq_oe_o, fl_ce_n_o, fl_we_n_o, fl_oe_n_o, fl_reset_n_o;
    logic [15:0] em [logic [21:0]];
    logic [15:0] bb [logic [21:0]];
    logic [3:0] offs [4] = '{4'h2, 4'h7, 4'h2, 4'h9};
    int error_cnt = 0, comparisons = 0, cyc = 0, seed = 32'h6d7e;
    always #10 mclk_i = ~mclk_i;
    fpcs_ctrl uut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i, .fl_ce_n_o, .fl_we_n_o, .fl_oe_n_o, .fl_reset_n_o);
    fpcs_flash_model fm (.addr_i(fl_addr_o), .dq_i(fl_dq_o), .ce_n_i(fl_ce_n_o), .we_n_i(fl_we_n_o),
        .oe_n_i(fl_oe_n_o), .reset_n_i(fl_reset_n_o), .dq_o(fl_dq_i));
    task test_done;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 90000) begin error_cnt++; test_done; end
    end
    task chk(string n, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end
    endtask : chk
    task wr(logic [7:0] ad, logic [31:0] v);
        @(posedge mclk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(logic [7:0] ad);
        @(posedge mclk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 st = reg_rdata_o;
    endtask : rd
    task op(logic [3:0] o, logic [21:0] ad, logic [15:0] v);
        int n;
        n = 0;
        wr(fpcs_pkg::REG_ADDR, {10'h000, ad});
        wr(fpcs_pkg::REG_DATA, {16'h0000, v});
        wr(fpcs_pkg::REG_CTRL, {28'h0, o});
        do begin rd(fpcs_pkg::REG_STAT); n++; end while (st[0] !== 1'b0 && n < 300);
    endtask : op
    function automatic logic [15:0] ex(logic [21:0] ad);
        return em.exists(ad) ? em[ad] : 16'hFFFF;
    endfunction : ex
    task pollchk(logic [21:0] ad);
        int n;
        n = 0;
        do begin op(fpcs_pkg::OP_POLL, ad, 16'h0000); n++; end while (st[1] !== 1'b0 && n < 20);
        chk("readback", {16'h0000, st[31:16]}, {16'h0000, ex(ad)});
    endtask : pollchk
    task ec(logic e);
        rd(fpcs_pkg::REG_STAT);
        chk("err", st[5], e);
        wr(fpcs_pkg::REG_STAT, 32'h20);
    endtask : ec
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        a = {6'h03, 16'($random(seed))};
        for (int i = 0; i < 2; i++) begin
            d = 16'($random(seed));
            // bit 7 kept low on the rewrite so polling still sees completion
            if (i == 1) d[7] = 1'b0;
            op(fpcs_pkg::OP_WORD, a, d);
            em[a] = ex(a) & d;
            pollchk(a);
        end
        op(fpcs_pkg::OP_BENTER, a, 16'h0000);
        rd(fpcs_pkg::REG_STAT);
        chk("bypass", st[2], 1'b1);
        for (int i = 1; i < 3; i++) begin
            d = 16'($random(seed));
            op(fpcs_pkg::OP_BPROG, a + 22'(i), d);
            em[a + 22'(i)] = d;
            pollchk(a + 22'(i));
        end
        op(fpcs_pkg::OP_WORD, a, 16'h0000);
        ec(1'b1);
        op(fpcs_pkg::OP_BSTART, a, 16'h0000);
        ec(1'b1);
        op(fpcs_pkg::OP_BEXIT, a, 16'h0000);
        rd(fpcs_pkg::REG_STAT);
        chk("bypass", st[2], 1'b0);
        b = {6'h05, 12'($random(seed)), 4'h0};
        op(fpcs_pkg::OP_BSTART, b, 16'h0003);
        foreach (offs[k]) begin
            d = 16'($random(seed)) | 16'h0080;
            bb[b + 22'(offs[k])] = d;
            op(fpcs_pkg::OP_BLOAD, b + 22'(offs[k]), d);
        end
        rd(fpcs_pkg::REG_STAT);
        chk("remaining", st[12:8], 5'h00);
        op(fpcs_pkg::OP_BCONF, b, 16'h0000);
        foreach (bb[k]) em[k] = bb[k];
        pollchk(b + 22'h9);
        foreach (bb[k]) pollchk(k);
        chk("abort", st[7], 1'b0);
        op(fpcs_pkg::OP_BSTART, b, 16'h0010);
        ec(1'b1);
        op(fpcs_pkg::OP_RESET, a, 16'h0000);
        op(fpcs_pkg::OP_ABORT, a, 16'h0000);
        ec(1'b0);
        pollchk(a);
        op(fpcs_pkg::OP_RENTER, a, 16'h0000);
        rd(fpcs_pkg::REG_STAT);
        chk("region", st[3], 1'b1);
        op(fpcs_pkg::OP_BENTER, a, 16'h0000);
        ec(1'b1);
        op(fpcs_pkg::OP_REXIT, a, 16'h0000);
        rd(fpcs_pkg::REG_STAT);
        chk("region", st[3], 1'b0);
        op(fpcs_pkg::OP_WORD, a + 22'h14, 16'h1234);
        op(fpcs_pkg::OP_WORD, a, 16'h0000);
        ec(1'b1);
        op(fpcs_pkg::OP_HWRST, a, 16'h0000);
        rd(fpcs_pkg::REG_STAT);
        chk("progbusy", st[1], 1'b0);
        op(fpcs_pkg::OP_WORD, a + 22'h14, 16'h1234);
        em[a + 22'h14] = 16'h1234;
        pollchk(a + 22'h14);
        ec(1'b0);
        test_done;
    end
endmodule : test_flash_program_command_sequencer
`default_nettype wire
